// ==== rtl/dstc_pkg.sv ====
// Constants and types for the serial and track control of the channel DAC
// Notes on behaviour
// - Readback bits leave on rising serial clock, valid at following falling edge.
// - Interface select high picks serial, low picks parallel; open reads low.
// - Busy output stays low for the whole acquisition, then returns high.
// - With track high, acquisition starts as soon as a channel is addressed.
// - With track low, input feeds output stage; acquisition waits for track rise.
// - Track low pulse of 90 to 200 ns resets every node to power-on state; here DOUT and the shift registers keep their values.
// - Frame sync high means idle; input activity then changes no channel.
// - Shared select pin is chip select in parallel, frame sync in serial.
// - Track pulse under 90 ns is ignored; over 200 ns acts as track.
// - First two word bits are mode: 00 acquisition, 01 direct DAC code.
package dstc_pkg;
  localparam int CLK_PERIOD_NS    = 8;
  localparam int TRK_MIN_NS       = 90;
  localparam int TRK_MAX_NS       = 200;
  localparam int ACQ_TIME_NS      = 16000;
  // Least time rounds up, longest time rounds down
  localparam int TRK_MIN_CYC      = (TRK_MIN_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int TRK_MAX_CYC      = TRK_MAX_NS / CLK_PERIOD_NS;
  localparam int ACQ_CYC          = ACQ_TIME_NS / CLK_PERIOD_NS;
  localparam int MODE_W           = 2;
  localparam int ADDR_W           = 5;
  localparam int CODE_W           = 14;
  localparam int NCHAN            = 32;
  localparam int HDR_BITS         = MODE_W + ADDR_W;
  localparam int WORD_BITS        = HDR_BITS + CODE_W;
  localparam int CNT_W            = 5;
  localparam int TRK_CNT_W        = 6;
  localparam int ACQ_CNT_W        = 12;
  localparam int SYNC_W           = 5;
  // Synchroniser bit positions
  localparam int SI_SCLK          = 0;
  localparam int SI_DIN           = 1;
  localparam int SI_FSYNC         = 2;
  localparam int SI_SEL           = 3;
  localparam int SI_TRACK         = 4;
  // Pin levels seen before the first sample: pulls on the pins
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h16;
  localparam logic [1:0] MODE_SAMPLE_HOLD_ACQUIRE_MODE = 2'h0;
  localparam logic [1:0] MODE_DAC  = 2'h1;
  localparam logic [1:0] MODE_READ = 2'h2;
  localparam logic [CODE_W-1:0] CODE_RST = 14'h0000;
  typedef enum logic [1:0] {ST_IDLE, ST_PEND, ST_ACQ} dstc_acq_t;
endpackage

// ==== rtl/dstc_chan_mem.sv ====
// Per-channel code store with registered read and whole-array clear
`timescale 1ns/1ps
`default_nettype none
module dstc_chan_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 14,
  parameter int AW    = 5
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             clr,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Storage; clear returns every channel to code zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (ce) begin
      if (clr) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem_q[i] <= '0;
        end
      end else if (we) begin
        mem_q[waddr] <= wdata;
      end
    end
  end

  // Registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem_q[raddr];
    end
  end
endmodule
`default_nettype wire

// ==== rtl/dstc_top.sv ====
// Serial word intake, readback, track/reset timing and acquisition control
`timescale 1ns/1ps
`default_nettype none
module dstc_top
  import dstc_pkg::*;
#(
  parameter int ACQ_CYCLES = ACQ_CYC
) (
  input  wire logic              CLOCK,
  input  wire logic              RESET,
  input  wire logic              CE,
  input  wire logic              SCLK,
  input  wire logic              DIN,
  input  wire logic              FSYNC_N,
  input  wire logic              INTERFACE_SELECT,
  input  wire logic              TRACK_N,
  input  wire logic [CODE_W-1:0] ADC_CODE,
  output logic                   DOUT,
  output logic                   BUSY_N,
  output logic                   ROUTE_VIN,
  output logic      [ADDR_W-1:0] CHAN_ADDR,
  output logic                   UPD_VALID,
  output logic      [ADDR_W-1:0] UPD_ADDR,
  output logic      [CODE_W-1:0] UPD_CODE,
  output logic                   SOFT_RESET
);
  logic [SYNC_W-1:0]    meta_q, sync_q, prev_q;
  logic                 sclk_fall, sclk_rise, trk_rise, active;
  logic [CNT_W-1:0]     bit_cnt_q;
  logic [WORD_BITS-1:0] sr_q;
  logic [MODE_W-1:0]    mode_q;
  logic [ADDR_W-1:0]    addr_q;
  logic                 hdr_done, word_done;
  logic [HDR_BITS-1:0]  hdr;
  logic [TRK_CNT_W-1:0] trk_cnt_q;
  logic                 in_window, too_long;
  dstc_acq_t            state_q;
  logic [ACQ_CNT_W-1:0] acq_cnt_q;
  logic                 acq_done, dac_wr, mem_we;
  logic [ADDR_W-1:0]    mem_waddr;
  logic [CODE_W-1:0]    mem_wdata, mem_rdata;
  logic                 rd_pend_q, out_act_q;
  logic [CODE_W-1:0]    out_sr_q;
  logic [ACQ_CNT_W:0]   busy_low_cnt;

  // Two-stage synchronisers; edges come from second and third stages
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
      prev_q <= SYNC_RST;
    end else if (CE) begin
      meta_q <= {TRACK_N, INTERFACE_SELECT, FSYNC_N, DIN, SCLK};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Frame is live only in serial mode with frame sync low
  assign active    = sync_q[SI_SEL] && !sync_q[SI_FSYNC];
  assign sclk_fall = prev_q[SI_SCLK] && !sync_q[SI_SCLK];
  assign sclk_rise = !prev_q[SI_SCLK] && sync_q[SI_SCLK];
  assign trk_rise  = !prev_q[SI_TRACK] && sync_q[SI_TRACK];
  assign hdr       = {sr_q[HDR_BITS-2:0], sync_q[SI_DIN]};
  assign hdr_done  = active && sclk_fall
                     && bit_cnt_q == CNT_W'(HDR_BITS - 1);
  assign word_done = active && sclk_fall && mode_q == MODE_DAC
                     && bit_cnt_q == CNT_W'(WORD_BITS - 1);
  // Glitch, reset and track windows from the internal clock count
  assign in_window = trk_cnt_q >= TRK_CNT_W'(TRK_MIN_CYC)
                     && trk_cnt_q <= TRK_CNT_W'(TRK_MAX_CYC);
  assign too_long  = trk_cnt_q > TRK_CNT_W'(TRK_MAX_CYC);

  // Input bits are sampled on the serial clock falling edge
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      bit_cnt_q <= '0;
      sr_q      <= '0;
    end else if (CE) begin
      if (SOFT_RESET || !active) begin
        bit_cnt_q <= '0;
      end else if (sclk_fall) begin
        sr_q <= {sr_q[WORD_BITS-2:0], sync_q[SI_DIN]};
        if (bit_cnt_q != '1) begin
          bit_cnt_q <= bit_cnt_q + CNT_W'(1);
        end
      end
    end
  end

  // Header capture: mode bits lead, then channel address
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      mode_q <= MODE_SAMPLE_HOLD_ACQUIRE_MODE;
      addr_q <= '0;
    end else if (CE) begin
      if (SOFT_RESET) begin
        mode_q <= MODE_SAMPLE_HOLD_ACQUIRE_MODE;
        addr_q <= '0;
      end else if (hdr_done) begin
        mode_q <= hdr[HDR_BITS-1 -: MODE_W];
        addr_q <= hdr[ADDR_W-1:0];
      end
    end
  end

  // Track low width, saturating just past the reset window
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      trk_cnt_q <= '0;
    end else if (CE) begin
      if (sync_q[SI_TRACK]) begin
        trk_cnt_q <= '0;
      end else if (!too_long) begin
        trk_cnt_q <= trk_cnt_q + TRK_CNT_W'(1);
      end
    end
  end

  // Reset pulse only for widths inside the window
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      SOFT_RESET <= 1'b0;
    end else if (CE) begin
      SOFT_RESET <= trk_rise && in_window;
    end
  end

  assign acq_done = state_q == ST_ACQ
                    && acq_cnt_q == ACQ_CNT_W'(ACQ_CYCLES - 1);
  assign dac_wr   = word_done;

  // Acquisition sequencer; a new address while busy is ignored
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state_q   <= ST_IDLE;
      acq_cnt_q <= '0;
      BUSY_N    <= 1'b1;
      ROUTE_VIN <= 1'b0;
      CHAN_ADDR <= '0;
    end else if (CE) begin
      if (SOFT_RESET) begin
        state_q   <= ST_IDLE;
        acq_cnt_q <= '0;
        BUSY_N    <= 1'b1;
        ROUTE_VIN <= 1'b0;
        CHAN_ADDR <= '0;
      end else begin
        unique case (state_q)
          ST_IDLE, ST_PEND: begin
            if (hdr_done && hdr[HDR_BITS-1 -: MODE_W] == MODE_SAMPLE_HOLD_ACQUIRE_MODE) begin
              CHAN_ADDR <= hdr[ADDR_W-1:0];
              if (sync_q[SI_TRACK]) begin
                state_q   <= ST_ACQ;
                acq_cnt_q <= '0;
                BUSY_N    <= 1'b0;
                ROUTE_VIN <= 1'b1;
              end else begin
                state_q   <= ST_PEND;
                ROUTE_VIN <= 1'b1;
              end
            end else if (state_q == ST_PEND && trk_rise && too_long) begin
              state_q   <= ST_ACQ;
              acq_cnt_q <= '0;
              BUSY_N    <= 1'b0;
            end
          end
          ST_ACQ: begin
            acq_cnt_q <= acq_cnt_q + ACQ_CNT_W'(1);
            if (acq_done) begin
              state_q   <= ST_IDLE;
              BUSY_N    <= 1'b1;
              ROUTE_VIN <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Finished acquisition outranks a coinciding serial code write
  assign mem_we    = acq_done || dac_wr;
  assign mem_waddr = acq_done ? CHAN_ADDR : addr_q;
  assign mem_wdata = acq_done ? ADC_CODE : {sr_q[CODE_W-2:0], sync_q[SI_DIN]};

  // Channel update strobe towards the output stages
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      UPD_VALID <= 1'b0;
      UPD_ADDR  <= '0;
      UPD_CODE  <= CODE_RST;
    end else if (CE) begin
      UPD_VALID <= mem_we && !SOFT_RESET;
      UPD_ADDR  <= mem_waddr;
      UPD_CODE  <= mem_wdata;
    end
  end

  dstc_chan_mem #(
    .DEPTH (NCHAN),
    .WIDTH (CODE_W),
    .AW    (ADDR_W)
  ) u_mem (
    .clk   (CLOCK),
    .rst   (RESET),
    .ce    (CE),
    .clr   (SOFT_RESET),
    .we    (mem_we && !SOFT_RESET),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (hdr_done ? hdr[ADDR_W-1:0] : addr_q),
    .rdata (mem_rdata)
  );

  // Readback: load stored code, then shift on rising serial clock
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      rd_pend_q <= 1'b0;
      out_act_q <= 1'b0;
      out_sr_q  <= '0;
      DOUT      <= 1'b0;
    end else if (CE) begin
      rd_pend_q <= hdr_done && hdr[HDR_BITS-1 -: MODE_W] == MODE_READ;
      if (SOFT_RESET || !active) begin
        out_act_q <= 1'b0;
      end else if (rd_pend_q) begin
        out_sr_q  <= mem_rdata;
        out_act_q <= 1'b1;
      end else if (out_act_q && sclk_rise) begin
        DOUT     <= out_sr_q[CODE_W-1];
        out_sr_q <= {out_sr_q[CODE_W-2:0], 1'b0};
      end
    end
  end

  // Helper: cycles spent with busy low
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      busy_low_cnt <= '0;
    end else if (CE) begin
      busy_low_cnt <= BUSY_N ? '0 : busy_low_cnt + (ACQ_CNT_W+1)'(1);
    end
  end

  // Counter already holds the last low cycle when the rise is seen
  property p_busy_len;
    @(posedge CLOCK) disable iff (RESET)
    $rose(BUSY_N) |-> busy_low_cnt == (ACQ_CNT_W+1)'(ACQ_CYCLES)
                      || $past(SOFT_RESET);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy low width wrong");

  property p_busy_switch;
    @(posedge CLOCK) disable iff (RESET)
    CE && acq_done && !SOFT_RESET |=> BUSY_N && !ROUTE_VIN && UPD_VALID
                                      && UPD_ADDR == CHAN_ADDR;
  endproperty
  a_busy_switch: assert property (p_busy_switch) else $error("switch late");

  property p_rst_window;
    @(posedge CLOCK) disable iff (RESET)
    CE && trk_rise && trk_cnt_q >= TRK_CNT_W'(TRK_MIN_CYC)
    && trk_cnt_q <= TRK_CNT_W'(TRK_MAX_CYC) |=> SOFT_RESET ##1 BUSY_N;
  endproperty
  a_rst_window: assert property (p_rst_window) else $error("no reset");

  property p_glitch;
    @(posedge CLOCK) disable iff (RESET)
    CE && trk_rise && (trk_cnt_q < TRK_CNT_W'(TRK_MIN_CYC)
    || trk_cnt_q > TRK_CNT_W'(TRK_MAX_CYC)) |=> !SOFT_RESET;
  endproperty
  a_glitch: assert property (p_glitch) else $error("bad reset");

  // An acquisition may end between frames; only link input is idled
  property p_idle;
    @(posedge CLOCK) disable iff (RESET)
    CE && !active && !acq_done |=> bit_cnt_q == '0 && !UPD_VALID;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not idle");

  property p_track_high;
    @(posedge CLOCK) disable iff (RESET)
    CE && state_q == ST_IDLE && hdr_done && sync_q[SI_TRACK]
    && hdr[HDR_BITS-1 -: MODE_W] == MODE_SAMPLE_HOLD_ACQUIRE_MODE && !SOFT_RESET
    |=> !BUSY_N && state_q == ST_ACQ;
  endproperty
  a_track_high: assert property (p_track_high) else $error("no start");

  property p_track_low;
    @(posedge CLOCK) disable iff (RESET)
    CE && state_q == ST_IDLE && hdr_done && !sync_q[SI_TRACK]
    && hdr[HDR_BITS-1 -: MODE_W] == MODE_SAMPLE_HOLD_ACQUIRE_MODE && !SOFT_RESET
    |=> ROUTE_VIN && BUSY_N && state_q == ST_PEND;
  endproperty
  a_track_low: assert property (p_track_low) else $error("no defer");

  property p_track_rise;
    @(posedge CLOCK) disable iff (RESET)
    CE && state_q == ST_PEND && trk_rise && too_long && !hdr_done
    && !SOFT_RESET |=> !BUSY_N && ROUTE_VIN;
  endproperty
  a_track_rise: assert property (p_track_rise) else $error("no acquire");

  property p_dout;
    @(posedge CLOCK) disable iff (RESET)
    CE && active && out_act_q && !rd_pend_q && sclk_rise && !SOFT_RESET
    |=> DOUT == $past(out_sr_q[CODE_W-1]);
  endproperty
  a_dout: assert property (p_dout) else $error("readback bit wrong");

  property p_dac_word;
    @(posedge CLOCK) disable iff (RESET)
    CE && word_done && !acq_done && !SOFT_RESET
    |=> UPD_VALID && UPD_ADDR == addr_q;
  endproperty
  a_dac_word: assert property (p_dac_word) else $error("code lost");
endmodule
`default_nettype wire

// ==== bench/dstc_host.sv ====
// Serial host model that frames words into the channel DAC control
`timescale 1ns/1ps
`default_nettype none
module dstc_host (
  output logic      SCLK,
  output logic      DIN,
  output logic      FSYNC_N,
  input  wire logic DOUT
);
  localparam int HALF_NS = 40; // 12.5 MHz keeps under the serial limit
  logic [13:0] rd_q;
  // Link clock parked low, data line left to its pull-up
  initial begin
    SCLK = 1'b0;
    DIN = 1'b1;
    FSYNC_N = 1'b1;
    rd_q = 14'h0000;
  end
  // One frame MSB first; sel low clocks with frame sync left high
  task automatic xfer(input logic [20:0] word, input int nbits,
                      input bit sel);
    // Frame sync stays high long enough for the sampler to see the gap
    FSYNC_N = 1'b1;
    #HALF_NS;
    FSYNC_N = ~sel;
    #HALF_NS;
    for (int i = 0; i < nbits; i++) begin
      SCLK = 1'b1;
      DIN = word[20-i];
      #HALF_NS;
      SCLK = 1'b0;
      rd_q = {rd_q[12:0], DOUT};
      #HALF_NS;
    end
    FSYNC_N = 1'b1;
    DIN = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_dstc_top.sv ====
// Self-checking bench for serial intake, track timing and acquisition
`timescale 1ns/1ps
`default_nettype none
module tb_dstc_top;
  import dstc_pkg::*;
  localparam int ACQ = 8; // Short acquisition keeps the run brief
  logic              CLOCK;
  logic              RESET;
  logic              TRACK_N;
  logic              INTERFACE_SELECT;
  logic [CODE_W-1:0] ADC_CODE;
  logic              SCLK;
  logic              DIN;
  logic              FSYNC_N;
  logic              DOUT;
  logic              BUSY_N;
  logic              ROUTE_VIN;
  logic [ADDR_W-1:0] CHAN_ADDR;
  logic              UPD_VALID;
  logic [ADDR_W-1:0] UPD_ADDR;
  logic [CODE_W-1:0] UPD_CODE;
  logic              SOFT_RESET;
  logic [ADDR_W-1:0] up_a;
  logic [CODE_W-1:0] up_c;
  int                n_errors = 0;
  int                num_checks = 0;
  int                upd_cnt = 0;
  int                low_cnt = 0;
  int                last_low = 0;

  dstc_top #(.ACQ_CYCLES(ACQ)) dut_u (
    .CLOCK(CLOCK), .RESET(RESET), .CE(1'b1), .SCLK(SCLK), .DIN(DIN),
    .FSYNC_N(FSYNC_N), .INTERFACE_SELECT(INTERFACE_SELECT),
    .TRACK_N(TRACK_N), .ADC_CODE(ADC_CODE), .DOUT(DOUT), .BUSY_N(BUSY_N),
    .ROUTE_VIN(ROUTE_VIN), .CHAN_ADDR(CHAN_ADDR), .UPD_VALID(UPD_VALID),
    .UPD_ADDR(UPD_ADDR), .UPD_CODE(UPD_CODE), .SOFT_RESET(SOFT_RESET)
  );
  dstc_host host_u (.SCLK(SCLK), .DIN(DIN), .FSYNC_N(FSYNC_N), .DOUT(DOUT));

  // 125 MHz system clock
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end

  // Busy length and update capture; update pulses are too short to poll
  always @(posedge CLOCK) begin
    if (UPD_VALID === 1'b1) begin
      upd_cnt <= upd_cnt + 1;
      up_a <= UPD_ADDR;
      up_c <= UPD_CODE;
    end
    if (BUSY_N === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end else if (low_cnt != 0) begin
      last_low <= low_cnt;
      low_cnt <= 0;
    end
  end

  task automatic chk_bit(input logic act, input logic exp);
    num_checks++;
    if (act !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic chk_val(input logic [CODE_W-1:0] act,
                         input logic [CODE_W-1:0] exp);
    num_checks++;
    if (act !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  // Sample just after an edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic set_track(input logic v);
    @(posedge CLOCK);
    TRACK_N <= v;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [CODE_W-1:0] c);
    host_u.xfer({MODE_READ, a, 14'h0000}, 21, 1'b1);
    chk_val(host_u.rd_q, c);
  endtask
  // Waits on the end of an acquisition, bounded
  task automatic acq_done(input logic [4:0] a, input logic [CODE_W-1:0] c);
    bit got;
    got = 1'b0;
    for (int i = 0; i < 60 && !got; i++) begin
      tick(1);
      got = (UPD_VALID === 1'b1);
    end
    chk_bit(got, 1'b1);
    chk_val(CODE_W'(UPD_ADDR), CODE_W'(a));
    chk_val(UPD_CODE, c);
    chk_bit(BUSY_N, 1'b1);
    chk_bit(ROUTE_VIN, 1'b0);
    tick(1);
    chk_val(CODE_W'(last_low), CODE_W'(ACQ));
  endtask

  task automatic t_acq_track_high;
    ADC_CODE <= 14'h1ABC;
    host_u.xfer({MODE_SAMPLE_HOLD_ACQUIRE_MODE, 5'h05, 14'h0000}, 7, 1'b1);
    tick(1);
    chk_bit(BUSY_N, 1'b0);
    chk_bit(ROUTE_VIN, 1'b1);
    chk_val(CODE_W'(CHAN_ADDR), 14'h0005);
    acq_done(5'h05, 14'h1ABC);
    $display("test acq_track_high done");
  endtask

  task automatic t_dac_readback;
    int n;
    n = upd_cnt;
    host_u.xfer({MODE_DAC, 5'h03, 14'h2A5C}, 21, 1'b1);
    tick(2);
    chk_val(CODE_W'(upd_cnt - n), 14'h0001);
    chk_val(CODE_W'(up_a), 14'h0003);
    chk_val(up_c, 14'h2A5C);
    rd_chk(5'h03, 14'h2A5C);
    rd_chk(5'h05, 14'h1ABC);
    $display("test dac_readback done");
  endtask

  task automatic t_track_low;
    ADC_CODE <= 14'h0F0F;
    set_track(1'b0);
    host_u.xfer({MODE_SAMPLE_HOLD_ACQUIRE_MODE, 5'h09, 14'h0000}, 7, 1'b1);
    tick(20);
    chk_bit(ROUTE_VIN, 1'b1);
    chk_bit(BUSY_N, 1'b1);
    set_track(1'b1);
    tick(6);
    chk_bit(BUSY_N, 1'b0);
    acq_done(5'h09, 14'h0F0F);
    $display("test track_low done");
  endtask

  task automatic t_refused;
    int n;
    n = upd_cnt;
    host_u.xfer({MODE_DAC, 5'h04, 14'h1234}, 21, 1'b0);
    @(posedge CLOCK);
    INTERFACE_SELECT <= 1'b0;
    host_u.xfer({MODE_DAC, 5'h04, 14'h1234}, 21, 1'b1);
    @(posedge CLOCK);
    INTERFACE_SELECT <= 1'b1;
    host_u.xfer({2'h3, 5'h04, 14'h1234}, 21, 1'b1);
    tick(4);
    chk_val(CODE_W'(upd_cnt - n), 14'h0000);
    chk_bit(BUSY_N, 1'b1);
    rd_chk(5'h04, 14'h0000);
    $display("test refused done");
  endtask

  // Pulse widths straddle the glitch and reset windows
  task automatic t_reset_pulse;
    int w[4] = '{10, 12, 25, 26};
    bit e[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    bit seen;
    for (int k = 0; k < 4; k++) begin
      set_track(1'b0);
      repeat (w[k]) @(posedge CLOCK);
      TRACK_N <= 1'b1;
      seen = 1'b0;
      repeat (10) begin
        tick(1);
        seen = seen | (SOFT_RESET === 1'b1);
      end
      chk_bit(seen, e[k]);
    end
    rd_chk(5'h03, 14'h0000);
    chk_bit(BUSY_N, 1'b1);
    $display("test reset_pulse done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    RESET = 1'b1;
    TRACK_N = 1'b1;
    INTERFACE_SELECT = 1'b1;
    ADC_CODE = 14'h0000;
    repeat (20) @(posedge CLOCK);
    RESET <= 1'b0;
    tick(5);
    chk_bit(BUSY_N, 1'b1);
    chk_bit(ROUTE_VIN, 1'b0);
    t_acq_track_high;
    t_dac_readback;
    t_track_low;
    t_refused;
    t_reset_pulse;
    end_of_test;
  end

  // Full 21-bit frames take about 2 us each, 7-bit header frames under 1 us; far beyond that means a hang
  initial begin
    #100us;
    n_errors++;
    $display("watchdog expired");
    end_of_test;
  end
endmodule
`default_nettype wire
